//--- design/ied_decoder.sv
// Purpose: Registered decoder for a slice of the 32-bit instruction encodings
// Assumes: One instruction offered per cycle with a valid strobe
// Notes: Result appears one cycle after the instruction is offered
`timescale 1ns/1ns
module ied_decoder (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output ied_pkg::ied_dec_s dec_out,
  output logic dec_valid
);
  import ied_pkg::*;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [5:0] pri;     // Bits 0..5, top of word
  logic [4:0] xlead;   // Bits 21..25
  logic [4:0] xtrail;  // Bits 26..30
  logic fin;           // Bit 31, the word lsb
  logic [4:0] sub;     // Bits 16..20, intermediate subcode
  logic [2:0] d8sel;   // Bits 21..23 of disp8 form
  logic [2:0] bfhi;    // Bits 6..8 of scaled imm8 compare
  ied_dec_s dec_d;     // Combinational decode
  ied_dec_s dec_q;     // Registered decode
  logic vld_q;         // Registered valid

  // Numbering puts instruction bit 0 at word bit 31
  assign pri = instr_word[IED_PRI_MSB:IED_PRI_LSB];
  assign xlead = instr_word[10:6];
  assign xtrail = instr_word[5:1];
  assign fin = instr_word[0];
  assign sub = instr_word[15:11];
  assign d8sel = instr_word[10:8];
  assign bfhi = instr_word[25:23];

  // ----------------------------------------------------------------
  // Register-form decode under primary 011111
  // ----------------------------------------------------------------
  function automatic ied_dec_s dec_x(input logic [4:0] ld, input logic [4:0] tr, input logic f);
    ied_dec_s r;
    r = '{op: IED_ILLEGAL, rec_cr: 1'b0, rec_ov: 1'b0, illegal: 1'b1};
    case (tr)
      IED_XT_CMP: begin
        if (ld == 5'h00) r.op = IED_CMP_W;
        else if (ld == 5'h01) r.op = IED_CMPL_W;
        else if (ld == 5'h10) r.op = IED_MCRXR;
      end
      IED_XT_CMPH: begin
        if (ld == 5'h00) r.op = IED_CMPH;
        else if (ld == 5'h01) r.op = IED_CMPHL;
      end
      IED_XT_CR: begin
        case (ld)
          5'h08: r.op = IED_CR_AND;
          5'h04: r.op = IED_CR_ANDC;
          5'h09: r.op = IED_CR_EQV;
          5'h07: r.op = IED_CR_NAND;
          5'h01: r.op = IED_CR_NOR;
          5'h0E: r.op = IED_CR_OR;
          5'h0D: r.op = IED_CR_ORC;
          5'h06: r.op = IED_CR_XOR;
          default: r.op = IED_ILLEGAL;
        endcase
      end
      IED_XT_CACHE: begin
        case (ld)
          5'h17: r.op = IED_DC_ALLOC;
          5'h02: r.op = IED_DC_FLUSH;
          5'h0E: r.op = IED_DC_INV;
          5'h01: r.op = IED_DC_STORE;
          5'h08: r.op = IED_DC_TOUCH;
          5'h07: r.op = IED_DC_TOUCH_ST;
          5'h1F: r.op = IED_DC_ZERO;
          5'h18: r.op = IED_LD_HBRX;
          5'h10: r.op = IED_LD_WBRX;
          5'h1A: r.op = IED_MBAR;
          5'h12: r.op = IED_MSYNC;
          5'h1E: r.op = IED_IC_INV;
          5'h00: r.op = IED_IC_TOUCH;
          default: r.op = IED_ILLEGAL;
        endcase
      end
      IED_XT_MDIV: begin
        // Divides: msb of leading field marks overflow form
        if (ld[3:0] == 4'hF) begin
          r.op = IED_DIVW;
          r.rec_ov = ld[4];
        end else if (ld[3:0] == 4'hE) begin
          r.op = IED_DIVWU;
          r.rec_ov = ld[4];
        end else if (ld[3:0] == 4'h7) begin
          r.op = IED_MULLW;
          r.rec_ov = ld[4];
        end else if (ld[3:0] == 4'h2) r.op = IED_MULHW;
        else if (ld[3:0] == 4'h0) r.op = IED_MULHWU;
        r.rec_cr = f;
      end
      IED_XT_EXT: begin
        if (ld == 5'h00) r.op = IED_CNTLZW;
        else if (ld == 5'h1D) r.op = IED_EXTSB;
        else if (ld == 5'h1C) r.op = IED_EXTSH;
        r.rec_cr = f;
      end
      IED_XT_LOG: begin
        case (ld)
          5'h08: r.op = IED_EQV;
          5'h0E: r.op = IED_NAND;
          5'h03: r.op = IED_NOR;
          5'h0D: r.op = IED_OR;
          5'h0C: r.op = IED_ORC;
          default: r.op = IED_ILLEGAL;
        endcase
        r.rec_cr = f;
      end
      IED_XT_LDX: begin
        case (ld)
          5'h02: r.op = IED_LD_BZX;
          5'h03: r.op = IED_LD_BZUX;
          5'h0A: r.op = IED_LD_HAX;
          5'h0B: r.op = IED_LD_HAUX;
          5'h08: r.op = IED_LD_HZX;
          5'h09: r.op = IED_LD_HZUX;
          5'h00: r.op = IED_LD_WZX;
          5'h01: r.op = IED_LD_WZUX;
          default: r.op = IED_ILLEGAL;
        endcase
      end
      IED_XT_LRSV: if (ld == 5'h00) r.op = IED_LD_WARX;
      IED_XT_MFR: begin
        if (ld == 5'h00) r.op = IED_MF_CR;
        else if (ld == 5'h02) r.op = IED_MF_MSR;
        else if (ld == 5'h0A) r.op = IED_MF_SPR;
        else if (ld == 5'h0E) r.op = IED_MT_SPR;
      end
      IED_XT_MSR: if (ld == 5'h04) r.op = IED_MT_MSR;
      IED_XT_MCR: begin
        if (ld == 5'h04) r.op = IED_MT_CRF;
        else if (ld == 5'h00) r.op = IED_MCRF;
      end
      IED_XT_DCR: begin
        if (ld == 5'h0A) r.op = IED_MF_DCR;
        else if (ld == 5'h0E) r.op = IED_MT_DCR;
      end
      IED_XT_ARTH: begin
        if (ld[3:0] == 4'h3) begin
          r.op = IED_NEG;
          r.rec_ov = ld[4];
        end
        r.rec_cr = f;
      end
      IED_XT_ROT: begin
        if (ld == 5'h08) r.op = IED_RLW;
        r.rec_cr = f;
      end
      default: r.op = IED_ILLEGAL;
    endcase
    r.illegal = (r.op == IED_ILLEGAL);
    if (r.illegal) begin
      r.rec_cr = 1'b0;
      r.rec_ov = 1'b0;
    end
    return r;
  endfunction : dec_x

  // ----------------------------------------------------------------
  // Top-level decode by primary opcode
  // ----------------------------------------------------------------
  always_comb begin
    dec_d = '{op: IED_ILLEGAL, rec_cr: 1'b0, rec_ov: 1'b0, illegal: 1'b1};
    case (pri)
      IED_OP_BR: begin
        // Only the 24-bit form with link belongs to this slice
        if (!instr_word[25] && fin) dec_d.op = IED_BRANCH_LINK;
      end
      IED_OP_X: dec_d = dec_x(xlead, xtrail, fin);
      IED_OP_I16: begin
        case (sub)
          5'h13: dec_d.op = IED_CMP_IMM;
          5'h15: dec_d.op = IED_CMPL_IMM;
          5'h16: dec_d.op = IED_CMPH_IMM;
          5'h17: dec_d.op = IED_CMPHL_IMM;
          5'h1C: dec_d.op = IED_LIS;
          5'h14: dec_d.op = IED_MUL_IMM;
          5'h18: dec_d.op = IED_OR_IMM;
          5'h1A: dec_d.op = IED_OR_IMM_SH;
          default: dec_d.op = IED_ILLEGAL;
        endcase
      end
      IED_OP_SCI: begin
        case (sub)
          5'h15: begin
            if (bfhi == 3'h0) dec_d.op = IED_CMP_IMM;
            else if (bfhi == 3'h1) dec_d.op = IED_CMPL_IMM;
          end
          5'h00: begin
            case (d8sel)
              3'h0: dec_d.op = IED_LD_BZU;
              3'h1: dec_d.op = IED_LD_HZU;
              3'h2: dec_d.op = IED_LD_WZU;
              3'h3: dec_d.op = IED_LD_HAU;
              default: dec_d.op = IED_ILLEGAL;
            endcase
          end
          5'h01: if (d8sel == 3'h0) dec_d.op = IED_LD_MW;
          5'h14: dec_d.op = IED_MUL_IMM;
          5'h1A: dec_d.op = IED_ORI;
          5'h1B: begin
            dec_d.op = IED_ORI;
            dec_d.rec_cr = 1'b1;
          end
          default: dec_d.op = IED_ILLEGAL;
        endcase
      end
      IED_OP_LBZ: dec_d.op = IED_LD_BZ;
      IED_OP_LHA: dec_d.op = IED_LD_HA;
      IED_OP_LHZ: dec_d.op = IED_LD_HZ;
      IED_OP_LWZ: dec_d.op = IED_LD_WZ;
      default: dec_d.op = IED_ILLEGAL;
    endcase
    dec_d.illegal = (dec_d.op == IED_ILLEGAL);
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Decode held when no new instruction arrives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_q <= '{op: IED_ILLEGAL, rec_cr: 1'b0, rec_ov: 1'b0, illegal: 1'b0};
    end else if (instr_valid) begin
      dec_q <= dec_d;
    end
  end

  // Valid follows the input strobe by one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) vld_q <= 1'b0;
    else vld_q <= instr_valid;
  end

  assign dec_out = dec_q;
  assign dec_valid = vld_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  branch_link_a: assert property (instr_valid && instr_word[31:26] == IED_OP_BR
    && !instr_word[25] && instr_word[0] |=> dec_out.op == IED_BRANCH_LINK)
    else $error("branch with link not decoded");
  cmp_word_a: assert property (instr_valid && instr_word[31:26] == IED_OP_X
    && instr_word[10:1] == 10'h020 |=> dec_out.op == IED_CMPL_W)
    else $error("unsigned word compare wrong");
  div_ov_a: assert property (instr_valid && instr_word[31:26] == IED_OP_X
    && instr_word[10:1] == 10'h3EB
    |=> dec_out.op == IED_DIVW && dec_out.rec_ov && dec_out.rec_cr == $past(instr_word[0]))
    else $error("divide overflow form wrong");
  // Unmatched words never carry record bits into the pipeline
  illegal_flag_a: assert property (dec_valid |-> dec_out.illegal == (dec_out.op == IED_ILLEGAL)
    && (!dec_out.illegal || (!dec_out.rec_cr && !dec_out.rec_ov)))
    else $error("illegal flag mismatch");
  valid_delay_a: assert property (instr_valid |=> dec_valid) else $error("valid not delayed by one");
  load_disp_a: assert property (instr_valid && instr_word[31:26] == IED_OP_LHA
    |=> dec_out.op == IED_LD_HA) else $error("halfword algebraic load wrong");
  sci_cmp_a: assert property (instr_valid && instr_word[31:23] == 9'h031
    && instr_word[15:11] == 5'h15 |=> dec_out.op == IED_CMPL_IMM)
    else $error("scaled unsigned compare wrong");
  lis_dec_a: assert property (instr_valid && instr_word[31:26] == IED_OP_I16
    && instr_word[15:11] == 5'h1C |=> dec_out.op == IED_LIS)
    else $error("load immediate shifted wrong");
  // Reserved primary space must come out flagged, not as some decoded class
  illegal_pri_a: assert property (instr_valid && instr_word[31:26] == 6'h3F
    |=> dec_out.illegal && !dec_out.rec_cr && !dec_out.rec_ov)
    else $error("reserved primary not flagged");

  cov_branch_c: cover property (dec_valid && dec_out.op == IED_BRANCH_LINK);
  cov_illegal_c: cover property (dec_valid && dec_out.illegal);
  cov_rec_c: cover property (dec_valid && dec_out.rec_cr && dec_out.rec_ov);

endmodule : ied_decoder

//--- design/ied_pkg.sv
// Purpose: Shared constants and types for the 32-bit instruction decoder slice
// Assumes: Bit 0 of an instruction is its most significant bit
// Notes: Field positions are given as packed indices of a [31:0] word
package ied_pkg;

  // ----------------------------------------------------------------
  // Field positions and opcode values
  // ----------------------------------------------------------------
  localparam int IED_PRI_MSB = 31;            // Primary opcode, bits 0..5
  localparam int IED_PRI_LSB = 26;
  localparam logic [5:0] IED_OP_X = 6'h1F;    // 011111 register forms
  localparam logic [5:0] IED_OP_I16 = 6'h1C;  // 011100 imm16 forms
  localparam logic [5:0] IED_OP_SCI = 6'h06;  // 000110 scaled imm8 / disp8
  localparam logic [5:0] IED_OP_BR = 6'h1E;   // 011110 branches
  localparam logic [5:0] IED_OP_LBZ = 6'h0C;  // 001100
  localparam logic [5:0] IED_OP_LHA = 6'h0E;  // 001110
  localparam logic [5:0] IED_OP_LHZ = 6'h16;  // 010110
  localparam logic [5:0] IED_OP_LWZ = 6'h14;  // 010100

  // Extended trailing subfields (bits 26..30)
  localparam logic [4:0] IED_XT_CMP = 5'h00;
  localparam logic [4:0] IED_XT_CR = 5'h01;
  localparam logic [4:0] IED_XT_DCR = 5'h03;
  localparam logic [4:0] IED_XT_ARTH = 5'h08;
  localparam logic [4:0] IED_XT_MDIV = 5'h0B;
  localparam logic [4:0] IED_XT_CMPH = 5'h0E;
  localparam logic [4:0] IED_XT_MCR = 5'h10;
  localparam logic [4:0] IED_XT_MSR = 5'h12;
  localparam logic [4:0] IED_XT_MFR = 5'h13;
  localparam logic [4:0] IED_XT_LRSV = 5'h14;
  localparam logic [4:0] IED_XT_CACHE = 5'h16;
  localparam logic [4:0] IED_XT_LDX = 5'h17;
  localparam logic [4:0] IED_XT_ROT = 5'h18;
  localparam logic [4:0] IED_XT_EXT = 5'h1A;
  localparam logic [4:0] IED_XT_LOG = 5'h1C;

  // ----------------------------------------------------------------
  // Decoded operation classes
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    IED_ILLEGAL, IED_BRANCH_LINK,
    IED_CMP_W, IED_CMPL_W, IED_CMPH, IED_CMPHL,
    IED_CMP_IMM, IED_CMPL_IMM, IED_CMPH_IMM, IED_CMPHL_IMM,
    IED_CNTLZW,
    IED_CR_AND, IED_CR_ANDC, IED_CR_EQV, IED_CR_NAND, IED_CR_NOR, IED_CR_OR,
    IED_CR_ORC, IED_CR_XOR,
    IED_DC_ALLOC, IED_DC_FLUSH, IED_DC_INV, IED_DC_STORE, IED_DC_TOUCH,
    IED_DC_TOUCH_ST, IED_DC_ZERO,
    IED_DIVW, IED_DIVWU, IED_EXTSB, IED_EXTSH,
    IED_EQV, IED_NAND, IED_NOR, IED_OR, IED_ORC,
    IED_LD_BZ, IED_LD_HA, IED_LD_HZ, IED_LD_WZ,
    IED_LD_BZU, IED_LD_HAU, IED_LD_HZU, IED_LD_WZU, IED_LD_MW,
    IED_LD_BZX, IED_LD_BZUX, IED_LD_HAX, IED_LD_HAUX, IED_LD_HZX, IED_LD_HZUX,
    IED_LD_WZX, IED_LD_WZUX, IED_LD_HBRX, IED_LD_WBRX, IED_LD_WARX,
    IED_LIS,
    IED_MF_CR, IED_MF_MSR, IED_MF_SPR, IED_MT_SPR, IED_MT_MSR, IED_MT_CRF,
    IED_MF_DCR, IED_MT_DCR, IED_MCRF, IED_MCRXR,
    IED_MBAR, IED_MSYNC, IED_IC_INV, IED_IC_TOUCH,
    IED_MULLW, IED_MULHW, IED_MULHWU, IED_MUL_IMM,
    IED_NEG, IED_OR_IMM, IED_OR_IMM_SH, IED_ORI, IED_RLW
  } ied_op_e;

  // Decoded result handed to the pipeline
  typedef struct packed {
    ied_op_e op;      // Operation class
    logic rec_cr;     // Condition register update variant
    logic rec_ov;     // Overflow recording variant
    logic illegal;    // No pattern matched
  } ied_dec_s;

endpackage : ied_pkg

//--- verif/ied_fetch_model.sv
// Purpose: Behavioural fetch stage that offers instruction words to the decoder
// Assumes: The bench sets fetch_req and fetch_word just after a falling edge
// Notes: While idle the word bus carries the inverse of the last word, never a stale copy
`timescale 1ns/1ns
module ied_fetch_model (
  input wire logic ref_clk,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_word,
  output logic instr_valid,
  output logic [31:0] instr_word
);
  // Last word handed over, so an idle bus can differ from it
  logic [31:0] last_q = 32'h0000_0000;

  // Remember each word the decoder takes
  always @(posedge ref_clk) begin
    if (fetch_req) begin
      last_q <= fetch_word;
    end
  end

  // Idle bus shows inverted data so a decoder that samples it out of turn is caught
  always_comb begin
    instr_valid = fetch_req;
    instr_word = fetch_req ? fetch_word : ~last_q;
  end
endmodule : ied_fetch_model

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the instruction decoder slice
// Assumes: Inputs change at the falling edge, results are read one cycle later
// Notes: Expected classes are written out by hand from the encodings
`timescale 1ns/1ns
module tb_top;
  import ied_pkg::*;
  logic ref_clk = 1'b0;            // 10 MHz core clock
  logic sys_rst = 1'b1;            // Synchronous reset, high
  logic fetch_req = 1'b0;          // Bench asks the fetch model to offer a word
  logic [31:0] fetch_word = 32'h0000_0000;
  logic instr_valid;
  logic [31:0] instr_word;
  ied_dec_s dec_out;
  logic dec_valid;
  ied_dec_s exp_last;              // Last decode expected, for hold checks
  int mismatches = 0;
  int total_checks = 0;

  // Clock: 100 ns period
  always #50 ref_clk = ~ref_clk;

  ied_fetch_model fetch (.ref_clk(ref_clk), .fetch_req(fetch_req), .fetch_word(fetch_word),
    .instr_valid(instr_valid), .instr_word(instr_word));
  ied_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .dec_out(dec_out), .dec_valid(dec_valid));

  // ------------------------------------------------------------
  // Encoders and compares
  // ------------------------------------------------------------
  function automatic logic [31:0] xw(input logic [4:0] l, input logic [4:0] t, input logic f);
    return {6'h1F, 15'h0000, l, t, f};
  endfunction : xw
  function automatic logic [31:0] iw(input logic [4:0] s);
    return {6'h1C, 10'h000, s, 11'h7FF};
  endfunction : iw
  function automatic logic [31:0] sw(input logic [2:0] h, input logic [4:0] s);
    return {6'h06, h, 7'h00, s, 11'h000};
  endfunction : sw
  function automatic logic [31:0] dw(input logic [4:0] s, input logic [2:0] h);
    return {6'h06, 10'h000, s, h, 8'h00};
  endfunction : dw
  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t valid got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_dec(input ied_dec_s got, input ied_dec_s exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t decode got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_dec
  // Offer one word and judge its decode; calls chain back to back
  task automatic chk(input logic [31:0] w, input ied_op_e op, input logic cr, input logic ov);
    ied_dec_s e;
    e.op = op;
    e.rec_cr = cr;
    e.rec_ov = ov;
    e.illegal = (op == IED_ILLEGAL);
    fetch_req = 1'b1;
    fetch_word = w;
    @(negedge ref_clk);
    cmp_bit(dec_valid, 1'b1);
    cmp_dec(dec_out, e);
    exp_last = e;
  endtask : chk
  task automatic x(input logic [4:0] l, input logic [4:0] t, input logic f, input ied_op_e op,
                   input logic cr, input logic ov);
    chk(xw(l, t, f), op, cr, ov);
  endtask : x
  // Plain register form: final bit clear, no record bits
  task automatic xz(input logic [4:0] l, input logic [4:0] t, input ied_op_e op);
    chk(xw(l, t, 1'b0), op, 1'b0, 1'b0);
  endtask : xz

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_idle();
    fetch_req = 1'b0;
    @(negedge ref_clk);
    cmp_bit(dec_valid, 1'b0);
    cmp_dec(dec_out, exp_last);
  endtask : t_idle
  // Reset in mid-run with a word offered: nothing is taken
  task automatic t_reset();
    fetch_req = 1'b1;
    fetch_word = 32'h7800_0001;
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    exp_last = '{op: IED_ILLEGAL, rec_cr: 1'b0, rec_ov: 1'b0, illegal: 1'b0};
    cmp_bit(dec_valid, 1'b0);
    cmp_dec(dec_out, exp_last);
  endtask : t_reset
  task automatic t_branch_cmp();
    chk(32'h7800_0001, IED_BRANCH_LINK, 1'b0, 1'b0);
    chk(32'h7800_0000, IED_ILLEGAL, 1'b0, 1'b0);
    chk(32'h7A00_0001, IED_ILLEGAL, 1'b0, 1'b0);
    xz(5'h00, 5'h00, IED_CMP_W);
    xz(5'h01, 5'h00, IED_CMPL_W);
    xz(5'h00, 5'h0E, IED_CMPH);
    xz(5'h01, 5'h0E, IED_CMPHL);
    chk(iw(5'h13), IED_CMP_IMM, 1'b0, 1'b0);
    chk(iw(5'h15), IED_CMPL_IMM, 1'b0, 1'b0);
    chk(iw(5'h16), IED_CMPH_IMM, 1'b0, 1'b0);
    chk(iw(5'h17), IED_CMPHL_IMM, 1'b0, 1'b0);
    chk(sw(3'h0, 5'h15), IED_CMP_IMM, 1'b0, 1'b0);
    chk(sw(3'h1, 5'h15), IED_CMPL_IMM, 1'b0, 1'b0);
    chk(sw(3'h2, 5'h15), IED_ILLEGAL, 1'b0, 1'b0);
  endtask : t_branch_cmp
  task automatic t_logic();
    x(5'h00, 5'h1A, 1'b0, IED_CNTLZW, 1'b0, 1'b0);
    x(5'h00, 5'h1A, 1'b1, IED_CNTLZW, 1'b1, 1'b0);
    xz(5'h08, 5'h01, IED_CR_AND);
    x(5'h08, 5'h01, 1'b1, IED_CR_AND, 1'b0, 1'b0);
    xz(5'h04, 5'h01, IED_CR_ANDC);
    xz(5'h09, 5'h01, IED_CR_EQV);
    xz(5'h07, 5'h01, IED_CR_NAND);
    xz(5'h01, 5'h01, IED_CR_NOR);
    xz(5'h0E, 5'h01, IED_CR_OR);
    xz(5'h0D, 5'h01, IED_CR_ORC);
    xz(5'h06, 5'h01, IED_CR_XOR);
    x(5'h08, 5'h1C, 1'b1, IED_EQV, 1'b1, 1'b0);
    xz(5'h0E, 5'h1C, IED_NAND);
    x(5'h03, 5'h1C, 1'b1, IED_NOR, 1'b1, 1'b0);
    xz(5'h0D, 5'h1C, IED_OR);
    xz(5'h0C, 5'h1C, IED_ORC);
    x(5'h1D, 5'h1A, 1'b1, IED_EXTSB, 1'b1, 1'b0);
    xz(5'h1C, 5'h1A, IED_EXTSH);
  endtask : t_logic
  task automatic t_cache_sync();
    xz(5'h17, 5'h16, IED_DC_ALLOC);
    xz(5'h02, 5'h16, IED_DC_FLUSH);
    xz(5'h0E, 5'h16, IED_DC_INV);
    xz(5'h01, 5'h16, IED_DC_STORE);
    xz(5'h08, 5'h16, IED_DC_TOUCH);
    xz(5'h07, 5'h16, IED_DC_TOUCH_ST);
    xz(5'h1F, 5'h16, IED_DC_ZERO);
    xz(5'h1A, 5'h16, IED_MBAR);
    xz(5'h12, 5'h16, IED_MSYNC);
    xz(5'h1E, 5'h16, IED_IC_INV);
    xz(5'h00, 5'h16, IED_IC_TOUCH);
  endtask : t_cache_sync
  task automatic t_arith();
    xz(5'h0F, 5'h0B, IED_DIVW);
    x(5'h0F, 5'h0B, 1'b1, IED_DIVW, 1'b1, 1'b0);
    xz(5'h0E, 5'h0B, IED_DIVWU);
    x(5'h1F, 5'h0B, 1'b0, IED_DIVW, 1'b0, 1'b1);
    x(5'h1E, 5'h0B, 1'b1, IED_DIVWU, 1'b1, 1'b1);
    xz(5'h07, 5'h0B, IED_MULLW);
    x(5'h17, 5'h0B, 1'b1, IED_MULLW, 1'b1, 1'b1);
    xz(5'h02, 5'h0B, IED_MULHW);
    x(5'h00, 5'h0B, 1'b1, IED_MULHWU, 1'b1, 1'b0);
    chk(iw(5'h14), IED_MUL_IMM, 1'b0, 1'b0);
    chk(sw(3'h0, 5'h14), IED_MUL_IMM, 1'b0, 1'b0);
    x(5'h03, 5'h08, 1'b1, IED_NEG, 1'b1, 1'b0);
    x(5'h13, 5'h08, 1'b0, IED_NEG, 1'b0, 1'b1);
  endtask : t_arith
  task automatic t_loads();
    chk({6'h0C, 26'h0}, IED_LD_BZ, 1'b0, 1'b0);
    chk({6'h0E, 26'h0}, IED_LD_HA, 1'b0, 1'b0);
    chk({6'h16, 26'h0}, IED_LD_HZ, 1'b0, 1'b0);
    chk({6'h14, 26'h0}, IED_LD_WZ, 1'b0, 1'b0);
    chk(dw(5'h00, 3'h0), IED_LD_BZU, 1'b0, 1'b0);
    chk(dw(5'h00, 3'h1), IED_LD_HZU, 1'b0, 1'b0);
    chk(dw(5'h00, 3'h2), IED_LD_WZU, 1'b0, 1'b0);
    chk(dw(5'h00, 3'h3), IED_LD_HAU, 1'b0, 1'b0);
    chk(dw(5'h01, 3'h0), IED_LD_MW, 1'b0, 1'b0);
    chk(dw(5'h00, 3'h4), IED_ILLEGAL, 1'b0, 1'b0);
    xz(5'h02, 5'h17, IED_LD_BZX);
    xz(5'h03, 5'h17, IED_LD_BZUX);
    xz(5'h0A, 5'h17, IED_LD_HAX);
    xz(5'h0B, 5'h17, IED_LD_HAUX);
    xz(5'h08, 5'h17, IED_LD_HZX);
    xz(5'h09, 5'h17, IED_LD_HZUX);
    xz(5'h00, 5'h17, IED_LD_WZX);
    xz(5'h01, 5'h17, IED_LD_WZUX);
    xz(5'h18, 5'h16, IED_LD_HBRX);
    xz(5'h10, 5'h16, IED_LD_WBRX);
    xz(5'h00, 5'h14, IED_LD_WARX);
    chk(iw(5'h1C), IED_LIS, 1'b0, 1'b0);
    chk(iw(5'h0C), IED_ILLEGAL, 1'b0, 1'b0);
  endtask : t_loads
  task automatic t_moves();
    xz(5'h00, 5'h13, IED_MF_CR);
    xz(5'h02, 5'h13, IED_MF_MSR);
    xz(5'h0A, 5'h13, IED_MF_SPR);
    xz(5'h0E, 5'h13, IED_MT_SPR);
    xz(5'h04, 5'h12, IED_MT_MSR);
    xz(5'h04, 5'h10, IED_MT_CRF);
    xz(5'h0A, 5'h03, IED_MF_DCR);
    xz(5'h0E, 5'h03, IED_MT_DCR);
    xz(5'h00, 5'h10, IED_MCRF);
    xz(5'h10, 5'h00, IED_MCRXR);
  endtask : t_moves
  task automatic t_or_illegal();
    chk(iw(5'h18), IED_OR_IMM, 1'b0, 1'b0);
    chk(iw(5'h1A), IED_OR_IMM_SH, 1'b0, 1'b0);
    chk(sw(3'h0, 5'h1A), IED_ORI, 1'b0, 1'b0);
    chk(sw(3'h0, 5'h1B), IED_ORI, 1'b1, 1'b0);
    x(5'h08, 5'h18, 1'b1, IED_RLW, 1'b1, 1'b0);
    xz(5'h08, 5'h0A, IED_ILLEGAL);
    chk(iw(5'h11), IED_ILLEGAL, 1'b0, 1'b0);
    chk(32'hFC00_0000, IED_ILLEGAL, 1'b0, 1'b0);
  endtask : t_or_illegal

  task automatic results();
    $display("Checks run %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Main sequence: reset 3 cycles, then scenarios back to back
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    t_branch_cmp();
    t_reset();
    t_idle();
    t_logic();
    t_cache_sync();
    t_idle();
    t_arith();
    t_reset();
    t_loads();
    t_moves();
    t_or_illegal();
    t_idle();
    results();
  end

  // Watchdog: about 105 cycles expected, give far more
  initial begin
    #1000000;
    mismatches++;
    results();
  end
endmodule : tb_top
